// *** logic/shift_move_pkg.sv ***
// How it works
// - the right shift result takes source bits 7:1 in its low seven bits and a zero at bit 7.
// - the right shift copies source bit 0 into carry and sets zero from the shifted result.
// - destination select 0 sends the result to the working register, 1 writes the file back.
// - the move-file op copies the file register unchanged to the selected destination.
// - the move-file op sets zero from the moved value, so a self-move works as a zero test.
// - the indirect load puts the addressed location into the working register and sets zero.
// - a one-bit pointer index picks one of the two pointer registers for the indirect load.
// - the pointer mode field codes 00 pre-increment, 01 pre-decrement, 10/11 post inc/dec.
// - pre modes access pointer plus or minus one, and the pointer keeps that new value.
// - post modes access the current pointer value, then step the pointer by one.
// - relative mode accesses pointer plus a signed offset of -32..31, pointer unchanged.
// - a file access to an indirect access port goes to the location held in its pointer.
// - pointers are 16 bits wide and stepping past either end wraps around.
// - pointer steps never touch carry, zero or any other status flag.
`default_nettype none

package shift_move_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;
   localparam int FADDR_W = 7;
   localparam int OFS_W = 6;
   localparam int REG_ADDR_W = 3;

   // ----------------------------------------
   // pointer mode field codes
   // ----------------------------------------
   localparam logic [1:0] MODE_PRE_INC = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;

   // ----------------------------------------
   // file addresses, destinations
   // ----------------------------------------
   localparam logic [FADDR_W-1:0] INDIRECT0_FADDR = 7'h00;
   localparam logic [FADDR_W-1:0] INDIRECT1_FADDR = 7'h01;
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // ----------------------------------------
   // register port map and fields
   // ----------------------------------------
   localparam logic [REG_ADDR_W-1:0] REG_WORK = 3'h0;
   localparam logic [REG_ADDR_W-1:0] REG_STATUS = 3'h1;
   localparam logic [REG_ADDR_W-1:0] REG_PTR0_LO = 3'h2;
   localparam logic [REG_ADDR_W-1:0] REG_PTR0_HI = 3'h3;
   localparam logic [REG_ADDR_W-1:0] REG_PTR1_LO = 3'h4;
   localparam logic [REG_ADDR_W-1:0] REG_PTR1_HI = 3'h5;
   localparam int CARRY_BIT = 0;
   localparam int ZERO_BIT = 2;
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
   localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
   localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

   typedef enum logic [1:0] {OP_NONE, OP_SHIFT_RIGHT, OP_MOVE_FILE, OP_INDIRECT_LOAD} op_kind_t;

   typedef struct packed {
      op_kind_t op;
      logic [FADDR_W-1:0] faddr;
      logic dest;
      logic ptr_idx;
      logic [1:0] mode;
      logic relative;
      logic [OFS_W-1:0] offset;
   } instr_t;

   typedef struct packed {
      logic carry;
      logic zero;
   } flags_t;

endpackage

`default_nettype wire

// *** logic/shift_move_indirect_exec.sv ***
`default_nettype none

module shift_move_indirect_exec
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   // ----------------------------------------
   // decoder side
   // ----------------------------------------
   input wire logic i_op_valid,
   input wire shift_move_pkg::instr_t i_op,
   output logic o_op_ready,
   output logic o_done,
   // ----------------------------------------
   // data memory side
   // ----------------------------------------
   output logic [shift_move_pkg::PTR_W-1:0] o_mem_addr,
   output logic o_mem_rd,
   input wire logic [shift_move_pkg::DATA_W-1:0] i_mem_rdata,
   output logic o_mem_wr,
   output logic [shift_move_pkg::DATA_W-1:0] o_mem_wdata,
   // ----------------------------------------
   // core state
   // ----------------------------------------
   output logic [shift_move_pkg::DATA_W-1:0] o_work,
   output shift_move_pkg::flags_t o_flags,
   output logic [shift_move_pkg::PTR_W-1:0] o_ptr0,
   output logic [shift_move_pkg::PTR_W-1:0] o_ptr1,
   // ----------------------------------------
   // register port
   // ----------------------------------------
   input wire logic [shift_move_pkg::REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [shift_move_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [shift_move_pkg::DATA_W-1:0] o_reg_rdata
);

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} state_t;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [shift_move_pkg::PTR_W-1:0] sext_offset(
      input logic [shift_move_pkg::OFS_W-1:0] ofs);
      sext_offset = {{(shift_move_pkg::PTR_W-shift_move_pkg::OFS_W){ofs[shift_move_pkg::OFS_W-1]}},
         ofs};
   endfunction

   // plain 16-bit add wraps by truncation
   function automatic logic [shift_move_pkg::PTR_W-1:0] step_ptr(
      input logic [shift_move_pkg::PTR_W-1:0] ptr,
      input logic down);
      step_ptr = down ? ptr - shift_move_pkg::PTR_ONE : ptr + shift_move_pkg::PTR_ONE;
   endfunction

   function automatic logic is_zero(input logic [shift_move_pkg::DATA_W-1:0] v);
      is_zero = (v == shift_move_pkg::DATA_ZERO);
   endfunction

   function automatic logic [shift_move_pkg::DATA_W-1:0] place_byte(
      input logic [shift_move_pkg::PTR_W-1:0] ptr,
      input logic hi);
      place_byte = hi ? ptr[shift_move_pkg::PTR_W-1:shift_move_pkg::DATA_W]
                      : ptr[shift_move_pkg::DATA_W-1:0];
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   state_t state_ff, nxt_state;
   shift_move_pkg::instr_t op_ff, nxt_op;
   logic [shift_move_pkg::PTR_W-1:0] addr_ff, nxt_addr;
   logic rd_ff, nxt_rd;
   logic wr_ff, nxt_wr;
   logic [shift_move_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
   logic [shift_move_pkg::DATA_W-1:0] work_ff, nxt_work;
   logic carry_ff, nxt_carry;
   logic zero_ff, nxt_zero;
   logic [shift_move_pkg::PTR_W-1:0] ptr_ff [2];
   logic [shift_move_pkg::PTR_W-1:0] nxt_ptr [2];
   logic done_ff, nxt_done;
   logic [shift_move_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;

   logic accept;
   logic [shift_move_pkg::PTR_W-1:0] cur_ptr;
   logic [shift_move_pkg::DATA_W-1:0] result;
   logic ptr_hi;
   logic ptr_n;

   assign o_op_ready = (state_ff == ST_IDLE);
   assign accept = i_op_valid && o_op_ready && (i_op.op != shift_move_pkg::OP_NONE);

   // ----------------------------------------
   // next values
   // ----------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_addr = addr_ff;
      nxt_rd = 1'b0;
      nxt_wr = 1'b0;
      nxt_wdata = wdata_ff;
      nxt_work = work_ff;
      nxt_carry = carry_ff;
      nxt_zero = zero_ff;
      nxt_ptr[0] = ptr_ff[0];
      nxt_ptr[1] = ptr_ff[1];
      nxt_done = 1'b0;
      nxt_rdata = shift_move_pkg::DATA_ZERO;
      cur_ptr = ptr_ff[i_op.ptr_idx];
      result = i_mem_rdata;
      ptr_hi = 1'b0;
      ptr_n = 1'b0;

      // software writes first so the execution unit overrides on a clash
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            shift_move_pkg::REG_WORK: nxt_work = i_reg_wdata;
            shift_move_pkg::REG_STATUS:
            begin
               nxt_carry = i_reg_wdata[shift_move_pkg::CARRY_BIT];
               nxt_zero = i_reg_wdata[shift_move_pkg::ZERO_BIT];
            end
            shift_move_pkg::REG_PTR0_LO,
            shift_move_pkg::REG_PTR0_HI,
            shift_move_pkg::REG_PTR1_LO,
            shift_move_pkg::REG_PTR1_HI:
            begin
               ptr_n = (i_reg_addr == shift_move_pkg::REG_PTR1_LO) ||
                       (i_reg_addr == shift_move_pkg::REG_PTR1_HI);
               ptr_hi = (i_reg_addr == shift_move_pkg::REG_PTR0_HI) ||
                        (i_reg_addr == shift_move_pkg::REG_PTR1_HI);
               if (ptr_hi)
               begin
                  nxt_ptr[ptr_n][shift_move_pkg::PTR_W-1:shift_move_pkg::DATA_W] = i_reg_wdata;
               end
               else
               begin
                  nxt_ptr[ptr_n][shift_move_pkg::DATA_W-1:0] = i_reg_wdata;
               end
            end
            default: ;
         endcase
      end

      if (i_reg_rd)
      begin
         case (i_reg_addr)
            shift_move_pkg::REG_WORK: nxt_rdata = work_ff;
            shift_move_pkg::REG_STATUS:
            begin
               nxt_rdata[shift_move_pkg::CARRY_BIT] = carry_ff;
               nxt_rdata[shift_move_pkg::ZERO_BIT] = zero_ff;
            end
            shift_move_pkg::REG_PTR0_LO: nxt_rdata = place_byte(ptr_ff[0], 1'b0);
            shift_move_pkg::REG_PTR0_HI: nxt_rdata = place_byte(ptr_ff[0], 1'b1);
            shift_move_pkg::REG_PTR1_LO: nxt_rdata = place_byte(ptr_ff[1], 1'b0);
            shift_move_pkg::REG_PTR1_HI: nxt_rdata = place_byte(ptr_ff[1], 1'b1);
            default: nxt_rdata = shift_move_pkg::DATA_ZERO;
         endcase
      end

      case (state_ff)
         ST_IDLE:
         begin
            if (accept)
            begin
               nxt_op = i_op;
               nxt_rd = 1'b1;
               nxt_state = ST_READ;
               if (i_op.op == shift_move_pkg::OP_INDIRECT_LOAD)
               begin
                  if (i_op.relative)
                  begin
                     nxt_addr = cur_ptr + sext_offset(i_op.offset);
                  end
                  else
                  begin
                     case (i_op.mode)
                        shift_move_pkg::MODE_PRE_INC,
                        shift_move_pkg::MODE_PRE_DEC:
                        begin
                           nxt_addr = step_ptr(cur_ptr, i_op.mode[0]);
                           nxt_ptr[i_op.ptr_idx] = step_ptr(cur_ptr, i_op.mode[0]);
                        end
                        default:
                        begin
                           nxt_addr = cur_ptr;
                           nxt_ptr[i_op.ptr_idx] = step_ptr(cur_ptr, i_op.mode[0]);
                        end
                     endcase
                  end
               end
               else if (i_op.faddr == shift_move_pkg::INDIRECT0_FADDR)
               begin
                  nxt_addr = ptr_ff[0];
               end
               else if (i_op.faddr == shift_move_pkg::INDIRECT1_FADDR)
               begin
                  nxt_addr = ptr_ff[1];
               end
               else
               begin
                  nxt_addr = {{(shift_move_pkg::PTR_W-shift_move_pkg::FADDR_W){1'b0}}, i_op.faddr};
               end
            end
         end
         ST_READ:
         begin
            // memory returns the byte in the following cycle
            nxt_state = ST_EXEC;
         end
         ST_EXEC:
         begin
            nxt_state = ST_IDLE;
            nxt_done = 1'b1;
            // carry and zero only move here or on a status register write, never on a pointer step
            case (op_ff.op)
               shift_move_pkg::OP_SHIFT_RIGHT:
               begin
                  result = {1'b0, i_mem_rdata[shift_move_pkg::DATA_W-1:1]};
                  nxt_carry = i_mem_rdata[0];
                  nxt_zero = is_zero(result);
               end
               shift_move_pkg::OP_MOVE_FILE:
               begin
                  result = i_mem_rdata;
                  nxt_zero = is_zero(result);
               end
               shift_move_pkg::OP_INDIRECT_LOAD:
               begin
                  result = i_mem_rdata;
                  nxt_zero = is_zero(result);
               end
               default: result = i_mem_rdata;
            endcase
            if (op_ff.op == shift_move_pkg::OP_INDIRECT_LOAD || op_ff.dest == shift_move_pkg::DEST_WORK)
            begin
               nxt_work = result;
            end
            else
            begin
               nxt_wr = 1'b1;
               nxt_wdata = result;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_ff <= ST_IDLE;
         op_ff <= '0;
         addr_ff <= shift_move_pkg::PTR_RST;
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         wdata_ff <= shift_move_pkg::DATA_ZERO;
         work_ff <= shift_move_pkg::WORK_RST;
         carry_ff <= 1'b0;
         zero_ff <= 1'b0;
         ptr_ff[0] <= shift_move_pkg::PTR_RST;
         ptr_ff[1] <= shift_move_pkg::PTR_RST;
         done_ff <= 1'b0;
         rdata_ff <= shift_move_pkg::DATA_ZERO;
      end
      else
      begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         addr_ff <= nxt_addr;
         rd_ff <= nxt_rd;
         wr_ff <= nxt_wr;
         wdata_ff <= nxt_wdata;
         work_ff <= nxt_work;
         carry_ff <= nxt_carry;
         zero_ff <= nxt_zero;
         ptr_ff[0] <= nxt_ptr[0];
         ptr_ff[1] <= nxt_ptr[1];
         done_ff <= nxt_done;
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_done = done_ff;
   assign o_mem_addr = addr_ff;
   assign o_mem_rd = rd_ff;
   assign o_mem_wr = wr_ff;
   assign o_mem_wdata = wdata_ff;
   assign o_work = work_ff;
   assign o_flags.carry = carry_ff;
   assign o_flags.zero = zero_ff;
   assign o_ptr0 = ptr_ff[0];
   assign o_ptr1 = ptr_ff[1];
   assign o_reg_rdata = rdata_ff;

endmodule // shift_move_indirect_exec

`default_nettype wire

// *** verification/shift_move_indirect_exec_monitor.sv ***
`default_nettype none

module shift_move_indirect_exec_monitor
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_op_valid,
   input wire shift_move_pkg::instr_t i_op,
   input wire logic o_op_ready,
   input wire logic o_done,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire shift_move_pkg::flags_t o_flags,
   input wire logic [shift_move_pkg::PTR_W-1:0] o_ptr0,
   input wire logic [shift_move_pkg::PTR_W-1:0] o_ptr1,
   input wire logic i_reg_wr
);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_take;
      i_op_valid && o_op_ready && (i_op.op != shift_move_pkg::OP_NONE);
   endsequence
   sequence s_busy;
      !o_op_ready [*2] ##1 (o_done && o_op_ready);
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_take_done: assert property (s_take |=> s_busy)
      else $error("op did not finish in three cycles");
   a_read_first: assert property (s_take |=> o_mem_rd ##1 !o_mem_rd)
      else $error("no single read after op taken");
   a_done_pulse: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   a_write_done: assert property (o_mem_wr |-> o_done && $past(o_mem_rd, 2))
      else $error("write outside done cycle");
   a_flags_only: assert property ($changed(o_flags) |-> o_done || $past(i_reg_wr))
      else $error("flags changed outside done");
   a_ptr_moment: assert property ($changed(o_ptr0) |-> o_mem_rd || $past(i_reg_wr))
      else $error("pointer 0 changed at wrong time");
   a_ptr1_moment: assert property ($changed(o_ptr1) |-> o_mem_rd || $past(i_reg_wr))
      else $error("pointer 1 changed at wrong time");
   a_step_one: assert property ($changed(o_ptr1) && o_mem_rd && !$past(i_reg_wr) |->
      (o_ptr1 == $past(o_ptr1) + 16'h0001) || (o_ptr1 == $past(o_ptr1) - 16'h0001))
      else $error("pointer step not one");
endmodule // shift_move_indirect_exec_monitor

bind shift_move_indirect_exec shift_move_indirect_exec_monitor u_mon
(
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_op_valid(i_op_valid),
   .i_op(i_op),
   .o_op_ready(o_op_ready),
   .o_done(o_done),
   .o_mem_rd(o_mem_rd),
   .o_mem_wr(o_mem_wr),
   .o_flags(o_flags),
   .o_ptr0(o_ptr0),
   .o_ptr1(o_ptr1),
   .i_reg_wr(i_reg_wr)
);

`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      shift_move_pkg::instr_t op;
      logic [15:0] a;
      logic [7:0] r;
      logic c;
      logic [15:0] p0;
      logic [15:0] p1;
   } row_t;
   logic i_clk, i_rst_n, i_op_valid, o_op_ready, o_done, o_mem_rd, o_mem_wr;
   logic i_reg_wr, i_reg_rd;
   shift_move_pkg::instr_t i_op;
   shift_move_pkg::flags_t o_flags;
   logic [15:0] o_mem_addr, o_ptr0, o_ptr1;
   logic [7:0] i_mem_rdata, o_mem_wdata, o_work, i_reg_wdata, o_reg_rdata, ew, rd;
   logic [2:0] i_reg_addr;
   row_t rows [12];
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   shift_move_indirect_exec u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready), .o_done(o_done),
      .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata),
      .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_work(o_work), .o_flags(o_flags),
      .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
   // ----------------------------------------
   // clock, memory, watchdog
   // ----------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // memory content is a[7:0]^a[15:8]; bus shows junk when not read
   always @(posedge i_clk)
   begin
      i_mem_rdata <= o_mem_rd ? (o_mem_addr[7:0] ^ o_mem_addr[15:8]) : ~i_mem_rdata;
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         finish_test();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
      cmp8(g[15:8], e[15:8]);
      cmp8(g[7:0], e[7:0]);
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
   endtask
   task automatic offer(input shift_move_pkg::instr_t op);
      @(posedge i_clk);
      i_op_valid <= 1'b1;
      i_op <= op;
      @(posedge i_clk);
      i_op_valid <= 1'b0;
   endtask
   task automatic run_row(input row_t r);
      logic wx;
      wx = (r.op.op != shift_move_pkg::OP_INDIRECT_LOAD) && r.op.dest;
      offer(r.op);
      for (int k = 0; k < 8 && o_done !== 1'b1; k++)
         @(posedge i_clk) #1;
      if (!wx)
         ew = r.r;
      cmp16(o_mem_addr, r.a);
      cmp8(o_work, ew);
      cmp8({5'h00, o_flags.carry, o_flags.zero, o_mem_wr}, {5'h00, r.c, r.r == 8'h00, wx});
      if (wx)
         cmp8(o_mem_wdata, r.r);
      cmp16(o_ptr0, r.p0);
      cmp16(o_ptr1, r.p1);
   endtask
   function automatic shift_move_pkg::instr_t mk(shift_move_pkg::op_kind_t o,
      logic [6:0] f, logic d, logic x, logic [1:0] m, logic l, logic [5:0] s);
      return '{o, f, d, x, m, l, s};
   endfunction
   task automatic finish_test();
      $display("checks=%0d errors=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      {i_rst_n, i_op_valid, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
      {i_op, ew} = '0;
      rows[0] = '{mk(shift_move_pkg::OP_SHIFT_RIGHT, 7'h10, 0, 0, 0, 0, 0), 16'h0010, 8'h08, 0,
         16'hffff, 16'h0000};
      rows[1] = '{mk(shift_move_pkg::OP_SHIFT_RIGHT, 7'h23, 1, 0, 0, 0, 0), 16'h0023, 8'h11, 1,
         16'hffff, 16'h0000};
      rows[2] = '{mk(shift_move_pkg::OP_MOVE_FILE, 7'h00, 0, 0, 0, 0, 0), 16'hffff, 8'h00, 1,
         16'hffff, 16'h0000};
      rows[3] = '{mk(shift_move_pkg::OP_MOVE_FILE, 7'h7f, 1, 0, 0, 0, 0), 16'h007f, 8'h7f, 1,
         16'hffff, 16'h0000};
      rows[4] = '{mk(shift_move_pkg::OP_INDIRECT_LOAD, 0, 0, 0, 2'h0, 0, 0), 16'h0000, 8'h00, 1,
         16'h0000, 16'h0000};
      rows[5] = '{mk(shift_move_pkg::OP_INDIRECT_LOAD, 0, 0, 1, 2'h3, 0, 0), 16'h0000, 8'h00, 1,
         16'h0000, 16'hffff};
      rows[6] = '{mk(shift_move_pkg::OP_INDIRECT_LOAD, 0, 0, 1, 2'h1, 0, 0), 16'hfffe, 8'h01, 1,
         16'h0000, 16'hfffe};
      rows[7] = '{mk(shift_move_pkg::OP_INDIRECT_LOAD, 0, 0, 0, 2'h2, 0, 0), 16'h0000, 8'h00, 1,
         16'h0001, 16'hfffe};
      rows[8] = '{mk(shift_move_pkg::OP_INDIRECT_LOAD, 0, 0, 0, 0, 1, 6'h20), 16'hffe1, 8'h1e, 1,
         16'h0001, 16'hfffe};
      rows[9] = '{mk(shift_move_pkg::OP_INDIRECT_LOAD, 0, 0, 1, 0, 1, 6'h1f), 16'h001d, 8'h1d, 1,
         16'h0001, 16'hfffe};
      rows[10] = '{mk(shift_move_pkg::OP_SHIFT_RIGHT, 7'h12, 0, 0, 0, 0, 0), 16'h0012, 8'h09, 0,
         16'h0001, 16'hfffe};
      rows[11] = '{mk(shift_move_pkg::OP_SHIFT_RIGHT, 7'h01, 1, 0, 0, 0, 0), 16'hfffe, 8'h00, 1,
         16'h0001, 16'hfffe};
      // look only after an edge has passed so the reset value has settled
      repeat (2) @(posedge i_clk);
      cmp8({7'h00, o_op_ready}, 8'h01);
      i_rst_n <= 1'b1;
      reg_wr(shift_move_pkg::REG_PTR0_LO, 8'hff);
      reg_wr(shift_move_pkg::REG_PTR0_HI, 8'hff);
      foreach (rows[i])
         run_row(rows[i]);
      reg_rd(shift_move_pkg::REG_STATUS, rd);
      cmp8(rd, 8'h05);
      reg_rd(shift_move_pkg::REG_WORK, rd);
      cmp8(rd, 8'h09);
      reg_rd(shift_move_pkg::REG_PTR1_LO, rd);
      cmp8(rd, 8'hfe);
      reg_wr(3'h6, 8'h5a);
      reg_rd(3'h6, rd);
      cmp8(rd, 8'h00);
      offer(mk(shift_move_pkg::OP_NONE, 7'h10, 0, 0, 0, 0, 0));
      // a taken op would show a read and a busy port in this very cycle
      #1 cmp8({5'h00, o_op_ready, o_mem_rd, o_done}, 8'h04);
      offer(rows[6].op);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      #1 cmp16(o_ptr1, 16'h0000);
      cmp16({6'h00, o_work, o_op_ready, o_done}, 16'h0002);
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rows[0] = '{mk(shift_move_pkg::OP_MOVE_FILE, 7'h01, 0, 0, 0, 0, 0), 16'h0000, 8'h00, 0,
         16'h0000, 16'h0000};
      run_row(rows[0]);
      finish_test();
   end
endmodule // tb_top

`default_nettype wire
